// [design/uart_pkg.sv]
// uart_pkg: register map, field positions, reset values and timing
// assumes a 32-bit ahb-lite bus, one aligned word per register
// Contract
// [R1] data write loads shifter now or after current stop
// [R2] each shifter load sets buffer empty
// [R3] start zero at bit 0, stop one at bit 9 or 10
// [R4] nine-bit load puts tx ninth bit at 9
// [R5] tick after load: start, data lsb first, stop
// [R6] pending data loads after stop; else empty stays
// [R7] tx done: nothing pending, stop held one bit
// [R8] tx enable makes its pin an output
// [R9] rx sampled 16 per bit; first low is sample 1
// [R10] two highs of samples 8,9,10 reject start
// [R11] data bit is majority of samples 8,9,10
// [R12] majority low stop sets frame error
// [R13] every character not dropped by overrun loads rx data, sets rx done
// [R14] data address: read rx data, write tx data
// [R15] nine-bit mode stores received ninth bit
// [R16] character over unread data sets overrun, dropped
// [R17] visible overrun updates on data read
// [R18] rx enable makes pin input; out bit sets pull-up
// [R19] nine-bit mode: nine data bits, else eight
// [R20] software sets tx ninth bit before data write
// [R21] software reads status first, data once
// [R22] rx done clears on data read
// [R23] tx done clears on ack or written one
// [R24] buffer empty set during reset
// [R25] double rate divides by 8, not 16; only the tx bit tick does, rx keeps 16 samples per bit
// [R26] enabled idle transmitter holds pin high

package uart_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_BAUD = 8'h0C;
    localparam logic [7:0] ADDR_PORT = 8'h10;

    // ****************************************************************
    // status fields
    // ****************************************************************
    localparam int ST_RX_DONE = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_TX_EMPTY = 5;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_OVERRUN = 3;
    localparam int ST_DOUBLE = 1;

    // ****************************************************************
    // control fields
    // ****************************************************************
    localparam int CT_RX_EN = 4;
    localparam int CT_TX_EN = 3;
    localparam int CT_NINE = 2;
    localparam int CT_RX_B8 = 1;
    localparam int CT_TX_B8 = 0;

    // port register fields: direction bits and output bits of both pins
    localparam int PT_DIR0 = 0;
    localparam int PT_DIR1 = 1;
    localparam int PT_OUT0 = 2;
    localparam int PT_OUT1 = 3;

    localparam logic [11:0] BAUD_RESET = 12'h0_000;
    localparam logic [4:0] OVS_NORMAL = 5'h10;
    localparam logic [4:0] OVS_DOUBLE = 5'h08;
    localparam logic [3:0] SAMPLE_A = 4'h8;
    localparam logic [3:0] SAMPLE_B = 4'h9;
    localparam logic [3:0] SAMPLE_C = 4'hA;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;

endpackage

// [design/uart_baud.sv]
// uart_baud: oversample tick divider and a bit tick every ovs ticks
// assumes divisor reload value from software; one clock domain
`timescale 1ns/1ps
module uart_baud #(
    parameter int DIV_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [DIV_W-1:0] divisor,
    input wire logic double_rate,
    output logic sample_tick,
    output logic bit_tick
);
    logic [DIV_W-1:0] div_q;
    logic [4:0] ovs_q;
    logic [4:0] ovs_top;

    // [R25]
    assign ovs_top = double_rate ? uart_pkg::OVS_DOUBLE : uart_pkg::OVS_NORMAL;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
            sample_tick <= 1'b0;
        end else if (div_q >= divisor) begin
            div_q <= '0;
            sample_tick <= 1'b1;
        end else begin
            div_q <= div_q + 1'b1;
            sample_tick <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovs_q <= '0;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (sample_tick) begin
                if (ovs_q >= ovs_top - 5'd1) begin
                    ovs_q <= '0;
                    bit_tick <= 1'b1;
                end else begin
                    ovs_q <= ovs_q + 5'd1;
                end
            end
        end
    end
endmodule

// [design/uart_rx.sv]
// uart_rx: start detection, majority voting and frame assembly
// assumes rx_pin already synchronised; sample_tick at 16x bit rate
`timescale 1ns/1ps
module uart_rx (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic nine_bit,
    input wire logic sample_tick,
    input wire logic rx_pin,
    output logic frame_done,
    output logic [8:0] frame_data,
    output logic frame_stop_ok
);
    uart_pkg::rx_state_t state_q;
    logic [3:0] samp_q;
    logic [3:0] bitn_q;
    logic [1:0] votes_q;
    logic [8:0] shift_q;
    logic vote;

    // two or more highs out of samples 8, 9, 10
    assign vote = (votes_q + {1'b0, rx_pin}) >= 2'd2;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= uart_pkg::RX_IDLE;
            samp_q <= '0;
            bitn_q <= '0;
            votes_q <= '0;
            shift_q <= '0;
            frame_done <= 1'b0;
            frame_data <= '0;
            frame_stop_ok <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (!enable) begin
                state_q <= uart_pkg::RX_IDLE;
            end else if (sample_tick) begin
                samp_q <= samp_q + 4'd1;
                if (samp_q == uart_pkg::SAMPLE_A ||
                    samp_q == uart_pkg::SAMPLE_B) begin
                    votes_q <= votes_q + {1'b0, rx_pin}; // [R11]
                end
                case (state_q)
                    uart_pkg::RX_IDLE: begin
                        if (!rx_pin) begin
                            // first low sample counts as sample 1
                            state_q <= uart_pkg::RX_START; // [R9]
                            samp_q <= 4'd2;
                            votes_q <= '0;
                        end
                    end
                    uart_pkg::RX_START: begin
                        if (samp_q == uart_pkg::SAMPLE_C) begin
                            votes_q <= '0;
                            if (vote) begin
                                state_q <= uart_pkg::RX_IDLE; // [R10]
                            end
                        end
                        if (samp_q == 4'd0) begin
                            state_q <= uart_pkg::RX_DATA;
                            samp_q <= 4'd1;
                            bitn_q <= '0;
                        end
                    end
                    uart_pkg::RX_DATA: begin
                        if (samp_q == uart_pkg::SAMPLE_C) begin
                            votes_q <= '0;
                            // lsb first; shift right from the top
                            if (nine_bit) begin // [R19]
                                shift_q <= {vote, shift_q[8:1]};
                            end else begin
                                shift_q <= {1'b0, vote, shift_q[7:1]};
                            end
                            bitn_q <= bitn_q + 4'd1;
                        end
                        if (samp_q == 4'd0) begin
                            samp_q <= 4'd1;
                            if (bitn_q == (nine_bit ? uart_pkg::BITS_NINE
                                                    : uart_pkg::BITS_EIGHT)) begin
                                state_q <= uart_pkg::RX_STOP;
                            end
                        end
                    end
                    uart_pkg::RX_STOP: begin
                        // finish at the stop's middle so a fast sender fits
                        if (samp_q == uart_pkg::SAMPLE_C) begin
                            votes_q <= '0;
                            frame_done <= 1'b1; // [R13]
                            frame_data <= shift_q;
                            frame_stop_ok <= vote; // [R12]
                            state_q <= uart_pkg::RX_IDLE;
                        end
                    end
                    default: state_q <= uart_pkg::RX_IDLE;
                endcase
            end
        end
    end
endmodule

// [design/uart_tx_rx_core.sv]
// uart_tx_rx_core: ahb-lite slave with serial transmitter and receiver
// assumes one ahb-lite master, whole-word single transfers, pins at top
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module uart_tx_rx_core (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic tx_done_ack,
    input wire logic port_pin_0_in,
    output logic port_pin_0_out,
    output logic port_pin_0_oe,
    output logic port_pin_0_pullup,
    input wire logic port_pin_1_in,
    output logic port_pin_1_out,
    output logic port_pin_1_oe
);
    // ****************************************************************
    // bus front end
    // ****************************************************************
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic acc_rd;
    logic [7:0] acc_addr;
    logic wr_data;
    logic rd_data;

    assign acc_rd = hsel && hready && htrans[1] && !hwrite;
    assign acc_addr = haddr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr;
        end
    end

    // zero wait states; every transfer answers okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign wr_data = wr_pend_q && wr_addr_q == uart_pkg::ADDR_DATA;
    assign rd_data = acc_rd && acc_addr == uart_pkg::ADDR_DATA;

    // ****************************************************************
    // software registers
    // ****************************************************************
    logic [4:0] ctrl_q;
    logic [11:0] baud_q;
    logic [3:0] port_q;
    logic double_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= '0;
            baud_q <= uart_pkg::BAUD_RESET;
            port_q <= '0;
            double_q <= 1'b0;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                uart_pkg::ADDR_CONTROL: begin
                    ctrl_q[uart_pkg::CT_RX_EN] <= hwdata[uart_pkg::CT_RX_EN];
                    ctrl_q[uart_pkg::CT_TX_EN] <= hwdata[uart_pkg::CT_TX_EN];
                    ctrl_q[uart_pkg::CT_NINE] <= hwdata[uart_pkg::CT_NINE];
                    ctrl_q[uart_pkg::CT_TX_B8] <= hwdata[uart_pkg::CT_TX_B8];
                end
                uart_pkg::ADDR_STATUS: double_q <= hwdata[uart_pkg::ST_DOUBLE];
                uart_pkg::ADDR_BAUD: baud_q <= hwdata[11:0];
                uart_pkg::ADDR_PORT: port_q <= hwdata[3:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // baud timing
    // ****************************************************************
    logic sample_tick;
    logic bit_tick;

    uart_baud #(.DIV_W(12)) u_baud (
        .hclk(hclk),
        .hresetn(hresetn),
        .divisor(baud_q),
        .double_rate(double_q),
        .sample_tick(sample_tick),
        .bit_tick(bit_tick)
    );

    // ****************************************************************
    // transmitter
    // ****************************************************************
    logic [8:0] tx_hold_q;
    logic tx_empty_q;
    logic [10:0] tx_shift_q;
    logic [3:0] tx_left_q;
    logic tx_busy_q;
    logic tx_done_q;
    logic tx_line_q;
    logic tx_load;
    logic tx_en;
    logic nine;

    assign tx_en = ctrl_q[uart_pkg::CT_TX_EN];
    assign nine = ctrl_q[uart_pkg::CT_NINE];
    // load when idle, or when the stop bit just finished
    assign tx_load = !tx_empty_q && bit_tick &&
                     (!tx_busy_q || tx_left_q == 4'd0); // [R1] [R6]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_hold_q <= '0;
            tx_empty_q <= 1'b1; // [R24]
        end else if (wr_data) begin
            // ninth bit sampled here, so it must be set beforehand
            tx_hold_q <= {ctrl_q[uart_pkg::CT_TX_B8], hwdata[7:0]}; // [R20]
            tx_empty_q <= 1'b0; // [R14]
        end else if (tx_load) begin
            tx_empty_q <= 1'b1; // [R2]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_shift_q <= '1;
            tx_left_q <= '0;
            tx_busy_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else if (tx_load) begin
            // start bit goes out on this same tick
            tx_line_q <= 1'b0; // [R5]
            tx_busy_q <= 1'b1;
            if (nine) begin // [R19]
                tx_shift_q <= {1'b1, 1'b1, tx_hold_q[8:0]}; // [R3] [R4]
                tx_left_q <= uart_pkg::BITS_NINE + 4'd1;
            end else begin
                tx_shift_q <= {2'b11, 1'b1, tx_hold_q[7:0]}; // [R3]
                tx_left_q <= uart_pkg::BITS_EIGHT + 4'd1;
            end
        end else if (bit_tick && tx_busy_q) begin
            if (tx_left_q == 4'd0) begin
                tx_busy_q <= 1'b0;
                tx_line_q <= 1'b1; // [R26]
            end else begin
                tx_line_q <= tx_shift_q[0]; // [R5]
                tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                tx_left_q <= tx_left_q - 4'd1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_done_q <= 1'b0;
        end else if (bit_tick && tx_busy_q && tx_left_q == 4'd0 &&
                     tx_empty_q) begin
            tx_done_q <= 1'b1; // [R7]
        end else if (tx_done_ack || (wr_pend_q &&
                     wr_addr_q == uart_pkg::ADDR_STATUS &&
                     hwdata[uart_pkg::ST_TX_DONE])) begin
            tx_done_q <= 1'b0; // [R23]
        end
    end

    // ****************************************************************
    // receiver
    // ****************************************************************
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_frame_done;
    logic [8:0] rx_frame;
    logic rx_stop_ok;
    logic [7:0] rx_data_q;
    logic rx_b8_q;
    logic rx_done_q;
    logic frame_err_q;
    logic over_hidden_q;
    logic over_vis_q;
    logic rx_en;

    assign rx_en = ctrl_q[uart_pkg::CT_RX_EN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= port_pin_0_in;
            rx_sync_q <= rx_meta_q;
        end
    end

    uart_rx u_rx (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(rx_en),
        .nine_bit(nine),
        .sample_tick(sample_tick),
        .rx_pin(rx_sync_q),
        .frame_done(rx_frame_done),
        .frame_data(rx_frame),
        .frame_stop_ok(rx_stop_ok)
    );

    // a new frame wins over a same-cycle read clearing rx done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_q <= '0;
            rx_b8_q <= 1'b1;
            rx_done_q <= 1'b0;
            frame_err_q <= 1'b0;
            over_hidden_q <= 1'b0;
        end else if (rx_frame_done && rx_done_q && !rd_data) begin
            over_hidden_q <= 1'b1; // [R16]
        end else if (rx_frame_done) begin
            rx_data_q <= rx_frame[7:0]; // [R13]
            if (nine) begin
                rx_b8_q <= rx_frame[8]; // [R15]
            end
            rx_done_q <= 1'b1; // [R13]
            frame_err_q <= !rx_stop_ok; // [R12]
            over_hidden_q <= 1'b0;
        end else if (rd_data) begin
            rx_done_q <= 1'b0; // [R22]
        end
    end

    // visible overrun follows the hidden one only on a data read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            over_vis_q <= 1'b0;
        end else if (rd_data) begin
            over_vis_q <= over_hidden_q; // [R17]
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (acc_rd) begin
            hrdata <= '0;
            case (acc_addr)
                uart_pkg::ADDR_DATA: hrdata[7:0] <= rx_data_q; // [R14]
                uart_pkg::ADDR_STATUS: begin
                    hrdata[uart_pkg::ST_RX_DONE] <= rx_done_q;
                    hrdata[uart_pkg::ST_TX_DONE] <= tx_done_q;
                    hrdata[uart_pkg::ST_TX_EMPTY] <= tx_empty_q;
                    hrdata[uart_pkg::ST_FRAME_ERR] <= frame_err_q;
                    hrdata[uart_pkg::ST_OVERRUN] <= over_vis_q;
                    hrdata[uart_pkg::ST_DOUBLE] <= double_q;
                end
                uart_pkg::ADDR_CONTROL: begin
                    hrdata[4:0] <= {ctrl_q[4:2], rx_b8_q, 1'b0};
                end
                uart_pkg::ADDR_BAUD: hrdata[11:0] <= baud_q;
                uart_pkg::ADDR_PORT: hrdata[3:0] <= port_q;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // pin ownership
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_pin_0_out <= 1'b0;
            port_pin_0_oe <= 1'b0;
            port_pin_0_pullup <= 1'b0;
            port_pin_1_out <= 1'b0;
            port_pin_1_oe <= 1'b0;
        end else begin
            port_pin_0_out <= port_q[uart_pkg::PT_OUT0];
            port_pin_0_oe <= !rx_en && port_q[uart_pkg::PT_DIR0]; // [R18]
            port_pin_0_pullup <= !port_q[uart_pkg::PT_DIR0] ||
                                 rx_en ? port_q[uart_pkg::PT_OUT0]
                                       : 1'b0; // [R18]
            port_pin_1_out <= tx_en ? tx_line_q
                                    : port_q[uart_pkg::PT_OUT1]; // [R8]
            port_pin_1_oe <= tx_en || port_q[uart_pkg::PT_DIR1]; // [R8]
        end
    end
endmodule

// [sim/uart_checker_properties.sv]
// uart_checker: bus and pin assertions on the core ports
// assumes a bind onto uart_tx_rx_core, one clock domain
`timescale 1ns/1ps
module uart_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic port_pin_0_oe,
    input wire logic port_pin_0_pullup,
    input wire logic port_pin_1_out,
    input wire logic port_pin_1_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_q;
    logic [7:0] wa_q, ctl_q, port_q;
    wire take = hsel && hready && htrans[1];
    // shadow of control and port bits, taken in the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_q <= take && hwrite;
            wa_q <= haddr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= 8'h00;
            port_q <= 8'h00;
        end else if (wr_q && wa_q == uart_pkg::ADDR_CONTROL) begin
            ctl_q <= hwdata[7:0];
        end else if (wr_q && wa_q == uart_pkg::ADDR_PORT) begin
            port_q <= hwdata[7:0];
        end
    end
    // a double-rate bit still lasts at least eight clocks
    sequence low_bit;
        !port_pin_1_out [*8];
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_unmapped_zero: assert property (take && !hwrite && haddr == 8'h20
        |=> hrdata == 32'h0000_0000) else $error("unmapped not zero");
    a_rdata_holds: assert property ($changed(hrdata)
        |-> $past(take && !hwrite)) else $error("hrdata moved");
    a_bit_length: assert property (port_pin_1_oe && $fell(port_pin_1_out)
        |-> low_bit) else $error("short low bit on tx");
    a_tx_owns_pin: assert property (ctl_q[uart_pkg::CT_TX_EN] [*3]
        |-> port_pin_1_oe) else $error("tx pin not output");
    a_rx_pin_input: assert property (ctl_q[uart_pkg::CT_RX_EN] [*3]
        |-> !port_pin_0_oe) else $error("rx pin driven");
    a_rx_pullup: assert property
        ((ctl_q[uart_pkg::CT_RX_EN] && $stable(port_q)) [*3]
        |-> port_pin_0_pullup == port_q[uart_pkg::PT_OUT0])
        else $error("bad pull-up");
endmodule

// [sim/uart_remote_node.sv]
// uart_remote_node: far serial node, sends on rx and samples tx
// assumes a bit time of BIT_CLKS hclk cycles
`timescale 1ns/1ps
module uart_remote_node #(
    parameter int BIT_CLKS = 16
) (
    input wire logic hclk,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        for (int i = 0; i <= n + 1; i++) begin
            line_out <= (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
            repeat (BIT_CLKS) @(posedge hclk);
        end
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge hclk);
    endtask
    // too short to survive the mid-bit vote
    task automatic spike;
        line_out <= 1'b0;
        repeat (3) @(posedge hclk);
        line_out <= 1'b1;
        repeat (BIT_CLKS * 2) @(posedge hclk);
    endtask
    // d holds data then the stop bit at position n
    task automatic recv(input int n, output logic [9:0] d);
        d = 10'h000;
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge hclk);
        for (int i = 0; i <= n; i++) begin
            repeat (BIT_CLKS) @(posedge hclk);
            d[i] = line_in;
        end
    endtask
endmodule

// [sim/tb_top.sv]
// tb_top: directed tests of the serial core over ahb-lite
// assumes divisor 0, so one bit is sixteen clocks
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rdv;
    logic hreadyout, hresp, out0, oe0, pu0, out1, oe1, node_line;
    int errors = 0;
    int samples_checked = 0;
    // undriven tx line rests high, as with a pull-up
    wire tx_line = oe1 ? out1 : 1'b1;
    wire rx_line = oe0 ? out0 : node_line;
    always #50 hclk = ~hclk;
    uart_tx_rx_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_done_ack(1'b0),
        .port_pin_0_in(rx_line), .port_pin_0_out(out0),
        .port_pin_0_oe(oe0), .port_pin_0_pullup(pu0),
        .port_pin_1_in(tx_line), .port_pin_1_out(out1), .port_pin_1_oe(oe1));
    uart_remote_node node (.hclk(hclk), .line_in(tx_line),
        .line_out(node_line));
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd = 32'h0000_0000);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic st(input string what, input int pos, input logic v);
        bus(1'b0, uart_pkg::ADDR_STATUS);
        check(what, v, rdv[pos]);
    endtask
    task automatic t_tx;
        logic [9:0] a, b;
        fork
            begin
                node.recv(8, a);
                node.recv(8, b);
            end
            begin
                bus(1'b1, uart_pkg::ADDR_DATA, 32'h0000_00A5);
                repeat (20) @(posedge hclk);
                bus(1'b1, uart_pkg::ADDR_DATA, 32'h0000_003C);
            end
        join
        check("frame a", 10'h1A5, a);
        check("frame b", 10'h13C, b);
        st("done early", uart_pkg::ST_TX_DONE, 1'b0);
        repeat (16) @(posedge hclk);
        st("done", uart_pkg::ST_TX_DONE, 1'b1);
        check("empty", 1'h1, rdv[uart_pkg::ST_TX_EMPTY]);
        bus(1'b1, uart_pkg::ADDR_STATUS, 32'h0000_0040);
        st("done cleared", uart_pkg::ST_TX_DONE, 1'b0);
        $display("tx test done");
    endtask
    task automatic t_tx9;
        logic [9:0] a;
        bus(1'b1, uart_pkg::ADDR_CONTROL, 32'h0000_001D);
        fork
            node.recv(9, a);
            bus(1'b1, uart_pkg::ADDR_DATA, 32'h0000_0055);
        join
        check("nine bit frame", 10'h355, a);
        repeat (16) @(posedge hclk);
        bus(1'b1, uart_pkg::ADDR_CONTROL, 32'h0000_0018);
        $display("nine bit test done");
    endtask
    task automatic t_rx;
        node.spike();
        node.send(9'h096, 8, 1'b1);
        st("rx done", uart_pkg::ST_RX_DONE, 1'b1);
        check("frame err", 1'h0, rdv[uart_pkg::ST_FRAME_ERR]);
        bus(1'b0, uart_pkg::ADDR_DATA);
        check("rx data", 32'h0000_0096, rdv);
        st("rx done read", uart_pkg::ST_RX_DONE, 1'b0);
        node.send(9'h011, 8, 1'b0);
        st("bad stop", uart_pkg::ST_FRAME_ERR, 1'b1);
        node.send(9'h022, 8, 1'b1);
        st("overrun hidden", uart_pkg::ST_OVERRUN, 1'b0);
        bus(1'b0, uart_pkg::ADDR_DATA);
        check("kept data", 32'h0000_0011, rdv);
        st("overrun", uart_pkg::ST_OVERRUN, 1'b1);
        $display("rx test done");
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        st("reset empty", uart_pkg::ST_TX_EMPTY, 1'b1);
        bus(1'b0, 8'h20);
        check("unmapped", 32'h0000_0000, rdv);
        bus(1'b1, uart_pkg::ADDR_PORT, 32'h0000_0004);
        bus(1'b1, uart_pkg::ADDR_CONTROL, 32'h0000_0018);
        t_tx();
        t_tx9();
        t_rx();
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        report_and_stop();
    end
endmodule
bind uart_tx_rx_core uart_checker chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_pin_0_oe(port_pin_0_oe),
    .port_pin_0_pullup(port_pin_0_pullup),
    .port_pin_1_out(port_pin_1_out), .port_pin_1_oe(port_pin_1_oe));
